// [output_terminal_function_mux.v]
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "terminal_mux_defines.vh"

module output_terminal_function_mux #(
    parameter FREQ_W = 16,
    parameter COUNT_W = 16
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,

    // register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,

    // drive state
    input wire init_done,
    input wire start_cmd,
    input wire dc_brake_active,
    input wire output_stop_input,
    input wire [FREQ_W-1:0] output_freq,
    input wire ipf_coasting,
    input wire ipf_restarting,
    input wire power_low,

    // fault latch control
    input wire fault_event,
    input wire fault_reset,

    // status sources
    input wire freq_reached_in,
    input wire pid_pause_flag,
    input wire protective_stop_monitor,
    input wire internal_guard_fault,
    input wire processor_fault,
    input wire [3:0] life_warning,
    input wire power_off_fault,
    input wire current_average_pulse,
    input wire [COUNT_W-1:0] maint_timer_count,
    input wire fan_warning,
    input wire comm_warning,

    // terminals, 1 = conducting
    output reg term_status_pin_q,
    output reg term_relay_q,
    output reg term_open_collector_q,

    // status flags
    output wire drive_ready_flag,
    output wire motor_output_active,
    output wire fault_flag
);

    // selector check: in range, and the pulse train is barred on the relay
    function sel_ok;
        input [7:0] code;
        input is_relay;
        reg [7:0] base;
        begin
            // fold negative codes
            base = (code >= `CODE_NEG_BASE) ? (code - `CODE_NEG_BASE) : code;
            sel_ok = (code <= `CODE_MAX) && !(is_relay && (base == `CODE_AVG_PULSE));
        end
    endfunction

    // software settings
    reg [7:0] terminal_sel_status_pin_q;
    reg [7:0] terminal_sel_relay_q;
    reg [7:0] terminal_sel_open_collector_q;
    // remote bits: pin, relay, oc
    reg [2:0] host_set_output_q;
    reg [FREQ_W-1:0] start_frequency_threshold_q;
    reg [COUNT_W-1:0] maint_threshold_q;

    // refusal flag
    reg sel_reject_q;

    // internal state
    reg fault_flag_q;
    reg fault_flag_d;

    // derived conditions
    wire output_shutoff;
    wire ready_blocked;
    wire above_start;
    wire running_raw;
    wire drive_ready_d;
    wire motor_active_d;

    // source conditions
    wire internal_guard_ok;
    wire wear_alarm;
    wire maintenance_due;
    wire light_alarm_flag;

    // decoder nets
    wire [`SRC_COUNT-1:0] src_flags;
    wire term_status_pin_d;
    wire term_relay_d;
    wire term_open_collector_d;

    // bus decode helpers
    wire wr_pin;
    wire wr_relay;
    wire wr_oc;
    wire bad_write;

    // strobes decode at their edge
    assign wr_pin = reg_wr && (reg_addr == `ADDR_SEL_STATUS_PIN);
    assign wr_relay = reg_wr && (reg_addr == `ADDR_SEL_RELAY);
    assign wr_oc = reg_wr && (reg_addr == `ADDR_SEL_OPEN_COLLECTOR);

    // a refused selector write leaves the old code in place
    assign bad_write = (wr_pin && !sel_ok(reg_wdata[7:0], 1'b0))
        || (wr_relay && !sel_ok(reg_wdata[7:0], 1'b1))
        || (wr_oc && !sel_ok(reg_wdata[7:0], 1'b0));

    // selector and setting registers
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            terminal_sel_status_pin_q <= `RST_SEL_STATUS_PIN;
            terminal_sel_relay_q <= `RST_SEL_RELAY;
            terminal_sel_open_collector_q <= `RST_SEL_OPEN_COLLECTOR;
            host_set_output_q <= 3'h0;
            start_frequency_threshold_q <= `RST_START_FREQ;
            maint_threshold_q <= `RST_MAINT_THRESHOLD;
        end else begin
            if (wr_pin && sel_ok(reg_wdata[7:0], 1'b0)) begin
                terminal_sel_status_pin_q <= reg_wdata[7:0];
            end

            if (wr_relay && sel_ok(reg_wdata[7:0], 1'b1)) begin
                terminal_sel_relay_q <= reg_wdata[7:0];
            end

            if (wr_oc && sel_ok(reg_wdata[7:0], 1'b0)) begin
                terminal_sel_open_collector_q <= reg_wdata[7:0];
            end

            // plain settings
            if (reg_wr && (reg_addr == `ADDR_HOST_SET_OUTPUT)) begin
                host_set_output_q <= reg_wdata[2:0];
            end

            if (reg_wr && (reg_addr == `ADDR_START_FREQ)) begin
                start_frequency_threshold_q <= reg_wdata[FREQ_W-1:0];
            end

            if (reg_wr && (reg_addr == `ADDR_MAINT_THRESHOLD)) begin
                maint_threshold_q <= reg_wdata[COUNT_W-1:0];
            end
        end
    end

    // sticky refusal flag; a new refusal beats a clear in the same cycle
    // bit 7 is write-one-to-clear
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_reject_q <= 1'b0;
        end else if (bad_write) begin
            sel_reject_q <= 1'b1;
        end else if (reg_wr && (reg_addr == `ADDR_STATUS)
                     && reg_wdata[`STAT_SEL_REJECT]) begin
            sel_reject_q <= 1'b0;
        end
    end

    // fault latch: set on a fault, cleared only by the fault reset
    always @* begin
        fault_flag_d = fault_flag_q;
        if (fault_event) begin
            fault_flag_d = 1'b1;
        end else if (fault_reset) begin
            fault_flag_d = 1'b0;
        end
    end

    // fault latch register
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_flag_q <= 1'b0;
        end else begin
            fault_flag_q <= fault_flag_d;
        end
    end

    // fault output
    assign fault_flag = fault_flag_q;

    // shutoff covers a latched fault, output stop and the safety stop
    assign output_shutoff = fault_flag_q || output_stop_input
        || protective_stop_monitor;

    // coasting with no start: not ready while supply is lost or low
    assign ready_blocked = ipf_coasting && !ipf_restarting
        && !start_cmd && power_low;

    // ready: set up, not shut off
    assign drive_ready_d = init_done && !output_shutoff
        && !ready_blocked;

    // running needs real output at or above the start threshold
    assign above_start = (output_freq != {FREQ_W{1'b0}})
        && (output_freq >= start_frequency_threshold_q);

    // restart after a dip counts as running even below threshold
    assign running_raw = ipf_restarting || (above_start && !ipf_coasting);

    // braking or shutoff stops running
    assign motor_active_d = running_raw && !dc_brake_active
        && !output_shutoff;

    // flags leave as levels
    assign drive_ready_flag = drive_ready_d;
    assign motor_output_active = motor_active_d;

    // plain status conditions from other units
    assign internal_guard_ok = !internal_guard_fault && !processor_fault;
    assign wear_alarm = |life_warning;
    assign light_alarm_flag = fan_warning || comm_warning;

    // count at or past threshold; a threshold of all ones means far off
    // unsigned compare
    assign maintenance_due = (maint_timer_count >= maint_threshold_q);

    // source vector shared by all three terminal decoders
    // order follows SRC_ positions
    assign src_flags[`SRC_RUNNING] = motor_active_d;
    assign src_flags[`SRC_FREQ_REACHED] = freq_reached_in;
    assign src_flags[`SRC_READY] = drive_ready_d;
    assign src_flags[`SRC_PID_PAUSE] = pid_pause_flag;
    assign src_flags[`SRC_PROT_STOP] = protective_stop_monitor;
    assign src_flags[`SRC_GUARD_OK] = internal_guard_ok;
    assign src_flags[`SRC_WEAR] = wear_alarm;
    assign src_flags[`SRC_POWER_OFF] = power_off_fault;
    assign src_flags[`SRC_AVG_PULSE] = current_average_pulse;
    assign src_flags[`SRC_MAINT_DUE] = maintenance_due;
    assign src_flags[`SRC_LIGHT_ALARM] = light_alarm_flag;
    assign src_flags[`SRC_FAULT] = fault_flag_q;

    // one decoder per terminal, so a code may be shared freely
    terminal_function_decode #(
        .SRC_W(`SRC_COUNT)
    ) u_dec_status_pin (
        .func_code(terminal_sel_status_pin_q),
        .src_flags(src_flags),
        .remote_bit(host_set_output_q[0]),
        .conduct(term_status_pin_d)
    );

    // relay: fast sources here wear the contact; sel_ok refuses the pulse train code, the rest is left to the host
    terminal_function_decode #(
        .SRC_W(`SRC_COUNT)
    ) u_dec_relay (
        .func_code(terminal_sel_relay_q),
        .src_flags(src_flags),
        .remote_bit(host_set_output_q[1]),
        .conduct(term_relay_d)
    );

    // open collector terminal
    terminal_function_decode #(
        .SRC_W(`SRC_COUNT)
    ) u_dec_open_collector (
        .func_code(terminal_sel_open_collector_q),
        .src_flags(src_flags),
        .remote_bit(host_set_output_q[2]),
        .conduct(term_open_collector_d)
    );

    // terminal drive registered; one cycle late but glitch free
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // all off while in reset
            term_status_pin_q <= 1'b0;
            term_relay_q <= 1'b0;
            term_open_collector_q <= 1'b0;
        end else begin
            term_status_pin_q <= term_status_pin_d;
            term_relay_q <= term_relay_d;
            term_open_collector_q <= term_open_collector_d;
        end
    end

    // status word seen by software
    wire [15:0] status_word;

    // upper byte reads as zero
    assign status_word = {8'h00, sel_reject_q, term_open_collector_q,
        term_relay_q, term_status_pin_q, maintenance_due,
        fault_flag_q, motor_active_d, drive_ready_d};

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_SEL_STATUS_PIN: reg_rdata_q <= {8'h00, terminal_sel_status_pin_q};
                `ADDR_SEL_RELAY: reg_rdata_q <= {8'h00, terminal_sel_relay_q};
                `ADDR_SEL_OPEN_COLLECTOR: reg_rdata_q <= {8'h00, terminal_sel_open_collector_q};
                `ADDR_HOST_SET_OUTPUT: reg_rdata_q <= {13'h0000, host_set_output_q};
                `ADDR_START_FREQ: reg_rdata_q <= start_frequency_threshold_q;
                `ADDR_MAINT_THRESHOLD: reg_rdata_q <= maint_threshold_q;
                `ADDR_STATUS: reg_rdata_q <= status_word;
                default: reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            // idle: back to zero
            reg_rdata_q <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// [output_terminal_function_mux_props.sv]
`timescale 1ns/10ps
`default_nettype none
module terminal_mux_props #(
    parameter FREQ_W = 16
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_q,
    input wire logic init_done,
    input wire logic start_cmd,
    input wire logic dc_brake_active,
    input wire logic output_stop_input,
    input wire logic [FREQ_W-1:0] output_freq,
    input wire logic ipf_coasting,
    input wire logic ipf_restarting,
    input wire logic power_low,
    input wire logic fault_event,
    input wire logic fault_reset,
    input wire logic protective_stop_monitor,
    input wire logic drive_ready_flag,
    input wire logic motor_output_active,
    input wire logic fault_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // any of these cuts the output stage
    wire shutoff = fault_flag | output_stop_input | protective_stop_monitor;
    // fault latch steps: set, hold, clear
    sequence s_fault_raise; fault_event; endsequence
    sequence s_fault_clear; fault_reset && !fault_event; endsequence
    property p_fault_set; s_fault_raise |=> fault_flag; endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set");
    property p_fault_hold; fault_flag && !fault_reset |=> fault_flag; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped");
    property p_fault_clear; s_fault_clear |=> !fault_flag; endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault flag stuck");
    property p_shutoff; shutoff |-> !drive_ready_flag && !motor_output_active; endproperty
    a_shutoff: assert property (p_shutoff) else $error("flags on during shutoff");
    property p_brake; dc_brake_active |-> !motor_output_active; endproperty
    a_brake: assert property (p_brake) else $error("running during braking");
    property p_run_src; motor_output_active |-> ipf_restarting || output_freq != 0; endproperty
    a_run_src: assert property (p_run_src) else $error("running while stopped");
    property p_coast; ipf_coasting && !ipf_restarting |-> !motor_output_active; endproperty
    a_coast: assert property (p_coast) else $error("running while coasting");
    property p_restart;
        ipf_restarting && !dc_brake_active && !shutoff |-> motor_output_active;
    endproperty
    a_restart: assert property (p_restart) else $error("not running on restart");
    property p_ready; init_done && !shutoff && !ipf_coasting |-> drive_ready_flag; endproperty
    a_ready: assert property (p_ready) else $error("ready flag missing");
    property p_power_loss;
        ipf_coasting && !ipf_restarting && !start_cmd && power_low |-> !drive_ready_flag;
    endproperty
    a_power_loss: assert property (p_power_loss) else $error("ready in power loss");
    property p_rdata_idle; !reg_rd |=> reg_rdata_q == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
endmodule
bind output_terminal_function_mux terminal_mux_props #(.FREQ_W(FREQ_W)) u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .init_done(init_done), .start_cmd(start_cmd), .dc_brake_active(dc_brake_active),
    .output_stop_input(output_stop_input), .output_freq(output_freq),
    .ipf_coasting(ipf_coasting), .ipf_restarting(ipf_restarting), .power_low(power_low),
    .fault_event(fault_event), .fault_reset(fault_reset),
    .protective_stop_monitor(protective_stop_monitor), .drive_ready_flag(drive_ready_flag),
    .motor_output_active(motor_output_active), .fault_flag(fault_flag));
`default_nettype wire

// [terminal_function_decode.v]
`timescale 1ns/10ps
`default_nettype none

`include "terminal_mux_defines.vh"

module terminal_function_decode #(
    parameter SRC_W = `SRC_COUNT
) (
    input wire [7:0] func_code,
    input wire [SRC_W-1:0] src_flags,
    input wire remote_bit,
    output reg conduct
);

    // maps a positive-form code to {supported, source index}
    function [4:0] map_code;
        input [7:0] base;
        begin
            case (base)
                `CODE_RUNNING: map_code = {1'b1, 4'd`SRC_RUNNING};
                `CODE_FREQ_REACHED: map_code = {1'b1, 4'd`SRC_FREQ_REACHED};
                `CODE_READY: map_code = {1'b1, 4'd`SRC_READY};
                `CODE_PID_PAUSE: map_code = {1'b1, 4'd`SRC_PID_PAUSE};
                `CODE_PROT_STOP: map_code = {1'b1, 4'd`SRC_PROT_STOP};
                `CODE_GUARD_OK: map_code = {1'b1, 4'd`SRC_GUARD_OK};
                `CODE_WEAR: map_code = {1'b1, 4'd`SRC_WEAR};
                `CODE_POWER_OFF: map_code = {1'b1, 4'd`SRC_POWER_OFF};
                `CODE_AVG_PULSE: map_code = {1'b1, 4'd`SRC_AVG_PULSE};
                `CODE_MAINT_DUE: map_code = {1'b1, 4'd`SRC_MAINT_DUE};
                `CODE_LIGHT_ALARM: map_code = {1'b1, 4'd`SRC_LIGHT_ALARM};
                `CODE_FAULT: map_code = {1'b1, 4'd`SRC_FAULT};
                default: map_code = 5'h00;
            endcase
        end
    endfunction

    reg neg;
    reg [7:0] base;
    reg [4:0] hit;
    reg active;

    // polarity split, then source pick; each terminal decodes on its own
    always @* begin
        neg = (func_code >= `CODE_NEG_BASE) && (func_code <= `CODE_MAX);
        base = neg ? (func_code - `CODE_NEG_BASE) : func_code;
        hit = map_code(base);
        active = 1'b0;
        if (func_code > `CODE_MAX) begin
            conduct = 1'b0; // out of range: no function
        end else if (base == `CODE_HOST_SET) begin
            conduct = remote_bit ^ neg;
        end else if (hit[4]) begin
            active = src_flags[hit[3:0]];
            conduct = active ^ neg;
        end else begin
            conduct = 1'b0; // unsupported code stays off
        end
    end

endmodule

`default_nettype wire

// [terminal_mux_defines.vh]
`ifndef TERMINAL_MUX_DEFINES_VH
`define TERMINAL_MUX_DEFINES_VH

// register word addresses on the plain register port
`define ADDR_SEL_STATUS_PIN 4'h0
`define ADDR_SEL_RELAY 4'h1
`define ADDR_SEL_OPEN_COLLECTOR 4'h2
`define ADDR_HOST_SET_OUTPUT 4'h3
`define ADDR_START_FREQ 4'h4
`define ADDR_MAINT_THRESHOLD 4'h5
`define ADDR_STATUS 4'h6

// function code ranges: 0..99 positive, 100..199 negative
`define CODE_NEG_BASE 8'h64
`define CODE_MAX 8'hC7

// function codes handled by the mux (positive form)
`define CODE_RUNNING 8'h00
`define CODE_FREQ_REACHED 8'h01
`define CODE_READY 8'h0B
`define CODE_PID_PAUSE 8'h46
`define CODE_PROT_STOP 8'h50
`define CODE_GUARD_OK 8'h51
`define CODE_WEAR 8'h5A
`define CODE_POWER_OFF 8'h5B
`define CODE_AVG_PULSE 8'h5D
`define CODE_MAINT_DUE 8'h5F
`define CODE_HOST_SET 8'h60
`define CODE_LIGHT_ALARM 8'h62
`define CODE_FAULT 8'h63

// positions in the internal source vector
`define SRC_RUNNING 0
`define SRC_FREQ_REACHED 1
`define SRC_READY 2
`define SRC_PID_PAUSE 3
`define SRC_PROT_STOP 4
`define SRC_GUARD_OK 5
`define SRC_WEAR 6
`define SRC_POWER_OFF 7
`define SRC_AVG_PULSE 8
`define SRC_MAINT_DUE 9
`define SRC_LIGHT_ALARM 10
`define SRC_FAULT 11
`define SRC_COUNT 12

// reset values of the selectors and settings
`define RST_SEL_STATUS_PIN 8'h00
`define RST_SEL_RELAY 8'h63
`define RST_SEL_OPEN_COLLECTOR 8'h01
`define RST_START_FREQ 16'h0000
`define RST_MAINT_THRESHOLD 16'hFFFF

// status register bit positions
`define STAT_READY 0
`define STAT_RUNNING 1
`define STAT_FAULT 2
`define STAT_MAINT_DUE 3
`define STAT_TERM_PIN 4
`define STAT_TERM_RELAY 5
`define STAT_TERM_OC 6
`define STAT_SEL_REJECT 7

`endif

// [terminal_reader.sv]
`timescale 1ns/10ps
`default_nettype none
module terminal_reader (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic term_pin,
    input wire logic term_relay,
    input wire logic term_oc,
    output logic seen_pin_q,
    output logic seen_relay_q,
    output logic seen_oc_q
);
    // input card latches each terminal once a clock; adds one cycle of lag
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {seen_pin_q, seen_relay_q, seen_oc_q} <= 3'h0;
        end else begin
            {seen_pin_q, seen_relay_q, seen_oc_q} <= {term_pin, term_relay, term_oc};
        end
    end
endmodule
`default_nettype wire

// [test_output_terminal_function_mux.sv]
`timescale 1ns/10ps
`default_nettype none
`include "terminal_mux_defines.vh"
module test_output_terminal_function_mux;
    logic sys_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, pol = 1'h0;
    logic [3:0] reg_addr = 4'h0, life_warning = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, output_freq = 16'h0000, maint_timer_count = 16'h0000;
    logic init_done = 1'h0, start_cmd = 1'h0, dc_brake_active = 1'h0, output_stop_input = 1'h0;
    logic ipf_coasting = 1'h0, ipf_restarting = 1'h0, power_low = 1'h0, fault_event = 1'h0;
    logic fault_reset = 1'h0, freq_reached_in = 1'h0, pid_pause_flag = 1'h0, fan_warning = 1'h0;
    logic protective_stop_monitor = 1'h0, internal_guard_fault = 1'h0, processor_fault = 1'h0;
    logic power_off_fault = 1'h0, current_average_pulse = 1'h0, comm_warning = 1'h0;
    logic [15:0] cw;
    wire [15:0] reg_rdata_q;
    wire term_status_pin_q, term_relay_q, term_open_collector_q;
    wire drive_ready_flag, motor_output_active, fault_flag, seen_pin_q, seen_relay_q, seen_oc_q;
    int error_cnt = 0, cmp_count = 0;

    output_terminal_function_mux #(.FREQ_W(16), .COUNT_W(16)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .init_done(init_done),
        .start_cmd(start_cmd), .dc_brake_active(dc_brake_active),
        .output_stop_input(output_stop_input), .output_freq(output_freq),
        .ipf_coasting(ipf_coasting), .ipf_restarting(ipf_restarting), .power_low(power_low),
        .fault_event(fault_event), .fault_reset(fault_reset), .freq_reached_in(freq_reached_in),
        .pid_pause_flag(pid_pause_flag), .protective_stop_monitor(protective_stop_monitor),
        .internal_guard_fault(internal_guard_fault), .processor_fault(processor_fault),
        .life_warning(life_warning), .power_off_fault(power_off_fault),
        .current_average_pulse(current_average_pulse), .maint_timer_count(maint_timer_count),
        .fan_warning(fan_warning), .comm_warning(comm_warning),
        .term_status_pin_q(term_status_pin_q), .term_relay_q(term_relay_q),
        .term_open_collector_q(term_open_collector_q), .drive_ready_flag(drive_ready_flag),
        .motor_output_active(motor_output_active), .fault_flag(fault_flag));
    terminal_reader partner (
        .sys_clk(sys_clk), .arst_n(arst_n), .term_pin(term_status_pin_q),
        .term_relay(term_relay_q), .term_oc(term_open_collector_q), .seen_pin_q(seen_pin_q),
        .seen_relay_q(seen_relay_q), .seen_oc_q(seen_oc_q));

    initial forever #10 sys_clk = ~sys_clk;

    task automatic stop_test;
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bus write: one strobe cycle, dropped at the next edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 chk16(reg_rdata_q, exp);
    endtask
    // terminal is registered and the reader adds a cycle, so wait three
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic flags(input logic r, input logic m);
        chk1(drive_ready_flag, r);
        chk1(motor_output_active, m);
        @(posedge sys_clk);
    endtask
    task automatic pulse_fault(input logic set);
        @(posedge sys_clk);
        if (set) fault_event <= 1'h1;
        else fault_reset <= 1'h1;
        @(posedge sys_clk);
        fault_event <= 1'h0;
        fault_reset <= 1'h0;
    endtask
    // neutral state: ready, stopped, fault cleared, only the ready and guard-ok sources active
    task automatic base;
        @(posedge sys_clk);
        init_done <= 1'h1;
        {start_cmd, dc_brake_active, output_stop_input, ipf_coasting, ipf_restarting} <= 5'h00;
        {power_low, pid_pause_flag, protective_stop_monitor, internal_guard_fault} <= 4'h0;
        {processor_fault, power_off_fault, current_average_pulse, fan_warning} <= 4'h0;
        {comm_warning, freq_reached_in, life_warning} <= 6'h00;
        {output_freq, maint_timer_count} <= 32'h0000_0000;
        pulse_fault(1'h0);
        wr(`ADDR_HOST_SET_OUTPUT, 16'h0000);
    endtask
    function automatic logic [7:0] code_of(input int i);
        case (i)
            0: return `CODE_RUNNING;
            1: return `CODE_FREQ_REACHED;
            2: return `CODE_READY;
            3: return `CODE_PID_PAUSE;
            4: return `CODE_PROT_STOP;
            5: return `CODE_GUARD_OK;
            6: return `CODE_WEAR;
            7: return `CODE_POWER_OFF;
            8: return `CODE_AVG_PULSE;
            9: return `CODE_MAINT_DUE;
            10: return `CODE_HOST_SET;
            11: return `CODE_LIGHT_ALARM;
            default: return `CODE_FAULT;
        endcase
    endfunction
    // drive the source behind code i active or idle; boundary values where counts matter
    task automatic set_src(input int i, input logic v);
        @(posedge sys_clk);
        case (i)
            0: output_freq <= v ? 16'h0100 : 16'h00ff;
            1: freq_reached_in <= v;
            2: init_done <= v;
            3: pid_pause_flag <= v;
            4: protective_stop_monitor <= v;
            5: {internal_guard_fault, processor_fault} <= v ? 2'h0 : (pol ? 2'h1 : 2'h2);
            6: life_warning <= v ? 4'h8 : 4'h0;
            7: power_off_fault <= v;
            8: current_average_pulse <= v;
            9: maint_timer_count <= v ? 16'h0010 : 16'h000f;
            10: wr(`ADDR_HOST_SET_OUTPUT, v ? 16'h0007 : 16'h0000);
            11: {fan_warning, comm_warning} <= {v & ~pol, v & pol};
            default: pulse_fault(v);
        endcase
    endtask

    initial begin
        repeat (50000) @(posedge sys_clk);
        error_cnt++;
        stop_test;
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'h1;
        rd(`ADDR_SEL_STATUS_PIN, 16'h0000);
        rd(`ADDR_SEL_RELAY, 16'h0063);
        rd(`ADDR_SEL_OPEN_COLLECTOR, 16'h0001);
        rd(`ADDR_MAINT_THRESHOLD, 16'hffff);
        rd(4'h9, 16'h0000);
        pulse_fault(1'h1);
        settle;
        chk1(seen_relay_q, 1'h1);
        chk1(fault_flag, 1'h1);
        pulse_fault(1'h0);
        settle;
        chk1(seen_relay_q, 1'h0);
        // refused selector writes keep the old code and set the sticky bit
        wr(`ADDR_SEL_RELAY, 16'h00c1);
        wr(`ADDR_SEL_STATUS_PIN, 16'h00c8);
        wr(4'h9, 16'h00ff);
        rd(`ADDR_SEL_RELAY, 16'h0063);
        rd(`ADDR_SEL_STATUS_PIN, 16'h0000);
        rd(`ADDR_STATUS, 16'h0080);
        wr(`ADDR_STATUS, 16'h0080);
        rd(`ADDR_STATUS, 16'h0000);
        wr(`ADDR_START_FREQ, 16'h0100);
        wr(`ADDR_MAINT_THRESHOLD, 16'h0010);
        // every code, both polarities, same code on all terminals at once, except the pulse code, which skips the relay
        for (int i = 0; i < 13; i++) begin
            for (int p = 0; p < 2; p++) begin
                pol = p[0];
                base;
                cw = {8'h00, code_of(i) + (pol ? `CODE_NEG_BASE : 8'h00)};
                wr(`ADDR_SEL_STATUS_PIN, cw);
                wr(`ADDR_SEL_OPEN_COLLECTOR, cw);
                if (i != 8) wr(`ADDR_SEL_RELAY, cw);
                for (int v = 0; v < 2; v++) begin
                    set_src(i, v[0]);
                    settle;
                    chk1(seen_pin_q, v[0] ^ pol);
                    chk1(seen_oc_q, v[0] ^ pol);
                    if (i != 8) chk1(seen_relay_q, v[0] ^ pol);
                end
            end
        end
        // ready and running across stop, braking, shutoff and power loss
        base;
        @(posedge sys_clk);
        start_cmd <= 1'h1;
        output_freq <= 16'h0100;
        settle;
        flags(1'h1, 1'h1);
        dc_brake_active <= 1'h1;
        settle;
        flags(1'h1, 1'h0);
        dc_brake_active <= 1'h0;
        output_stop_input <= 1'h1;
        settle;
        flags(1'h0, 1'h0);
        output_stop_input <= 1'h0;
        protective_stop_monitor <= 1'h1;
        settle;
        flags(1'h0, 1'h0);
        protective_stop_monitor <= 1'h0;
        ipf_coasting <= 1'h1;
        power_low <= 1'h1;
        settle;
        flags(1'h1, 1'h0);
        start_cmd <= 1'h0;
        settle;
        flags(1'h0, 1'h0);
        ipf_restarting <= 1'h1;
        settle;
        flags(1'h1, 1'h1);
        stop_test;
    end
endmodule
`default_nettype wire
